/* File: rtl/pfps_pkg.sv */
// Package: constants and types for the prefetch pipe and privilege state block
package pfps_pkg;

  localparam int unsigned PFPS_WORD_W  = 16;
  localparam int unsigned PFPS_LONG_W  = 32;
  localparam int unsigned PFPS_STAGES  = 3;

  // Space codes
  localparam logic [2:0] PFPS_FC_USER_DATA = 3'h1;
  localparam logic [2:0] PFPS_FC_USER_PROG = 3'h2;
  localparam logic [2:0] PFPS_FC_SUP_DATA  = 3'h5;
  localparam logic [2:0] PFPS_FC_SUP_PROG  = 3'h6;
  localparam logic [2:0] PFPS_FC_CPU       = 3'h7;

  // Status word bit positions
  localparam int unsigned PFPS_SW_S_BIT = 13;
  localparam int unsigned PFPS_SW_M_BIT = 12;

  // Values after reset
  localparam logic [15:0] PFPS_SW_RESET = 16'h2700;
  localparam logic [31:0] PFPS_SP_RESET = 32'h0000_0000;

  // Stack pointer select
  localparam logic [1:0] PFPS_SP_USER = 2'h0;
  localparam logic [1:0] PFPS_SP_IRQ  = 2'h1;
  localparam logic [1:0] PFPS_SP_TASK = 2'h2;

  // Bus access kinds from the sequencer
  localparam logic [1:0] PFPS_ACC_DATA = 2'h0;
  localparam logic [1:0] PFPS_ACC_PROG = 2'h1;
  localparam logic [1:0] PFPS_ACC_CPU  = 2'h2;

  typedef enum logic [1:0] {
    PFPS_ST_NORMAL    = 2'b00,
    PFPS_ST_EXCEPTION = 2'b01,
    PFPS_ST_HALTED    = 2'b10,
    PFPS_ST_STOPPED   = 2'b11
  } pfps_state_t;

endpackage : pfps_pkg

/* File: rtl/pfps_core.sv */
// Prefetch pipe, processing state machine and privilege control
//
// What this block does
// - Three word stages, decoded at third stage
// - Each stage flags words from faulted cycles
// - Stages load only on sequencer prefetch
// - Stages 16 bits; holding register 32 bits
// - Aligned prefetch fills holder and first stage
// - Next sequential prefetch served from holder
// - Holder feeds pipe with cache on or off
// - Request to all three; holder hit aborts bus
// - Unless halted, normal or exception processing
// - Exception ends when handler starts executing
// - Bus or address error in exception halts
// - Halted leaves only by external reset
// - Stop is normal state without bus cycles
// - Supervisor bit selects privilege and stack
// - Space codes mark supervisor or user
// - Master bit set selects task stack
// - Master bit clear selects irq stack
// - Reset starts supervisor interrupt mode
// - Master bit never changes privilege
// - Interrupt exception saves then clears master
// - Exception processing always at supervisor level
// - User privileged attempt traps to exception
// - Supervisor bit clear uses user stack
// - Space code encoding per access type
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pfps_core
  import pfps_pkg::*;
#(
  parameter int unsigned WORD_W = PFPS_WORD_W,
  parameter int unsigned LONG_W = PFPS_LONG_W
) (
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_resetn,
  // Sequencer prefetch request
  input  wire logic                i_pf_req,
  input  wire logic [31:0]         i_pf_addr,
  input  wire logic                i_pf_validate,
  input  wire logic                i_pipe_advance,
  input  wire logic                i_pipe_flush,
  // Instruction cache and bus controller answers
  input  wire logic                i_cache_hit,
  input  wire logic                i_bus_done,
  input  wire logic                i_bus_fault,
  input  wire logic [LONG_W-1:0]   i_fill_data,
  // Sequencer events
  input  wire logic                i_exc_start,
  input  wire logic                i_exc_is_irq,
  input  wire logic                i_handler_start,
  input  wire logic                i_exc_bus_error,
  input  wire logic                i_exc_addr_error,
  input  wire logic                i_stop_exec,
  input  wire logic                i_stop_wake,
  input  wire logic                i_priv_attempt,
  input  wire logic                i_sw_write,
  input  wire logic [15:0]         i_sw_wdata,
  input  wire logic [1:0]          i_acc_kind,
  input  wire logic                i_sp_write,
  input  wire logic [31:0]         i_sp_wdata,
  // Pipe outputs
  output logic [WORD_W-1:0]        o_decode_word,
  output logic                     o_decode_valid,
  output logic                     o_decode_fault,
  output logic [WORD_W-1:0]        o_stage1_word,
  output logic [WORD_W-1:0]        o_stage2_word,
  output logic                     o_holder_hit,
  output logic                     o_pf_done,
  // Bus side
  output logic                     o_bus_start,
  output logic                     o_bus_abort,
  output logic                     o_cache_lookup,
  output logic [2:0]               o_space_code,
  // State and privilege
  output logic [1:0]               o_proc_state,
  output logic                     o_halted,
  output logic                     o_priv_trap,
  output logic [15:0]              o_status_word,
  output logic                     o_saved_master,
  output logic [1:0]               o_sp_select,
  output logic [31:0]              o_stack_pointer
);

  ////////////////////////////////////////////////////////////////////////////
  // Pipe and holding register

  logic [WORD_W-1:0] stage_word  [PFPS_STAGES];
  logic              stage_valid [PFPS_STAGES];
  logic              stage_fault [PFPS_STAGES];
  logic [LONG_W-1:0] holder;
  logic [29:0]       holder_tag;
  logic              holder_valid;
  logic              holder_fault;
  logic              pf_pending;
  logic              pf_odd;
  logic [29:0]       pf_tag;

  wire        req_odd      = i_pf_addr[1];
  wire        holder_match = holder_valid && (holder_tag == i_pf_addr[31:2]);
  // Odd word of a held long word needs no cache or bus
  wire        holder_hit   = i_pf_req && req_odd && holder_match;
  wire        fill_ok      = pf_pending && (i_cache_hit || i_bus_done || i_bus_fault);
  wire        fill_fault   = i_bus_fault && !i_cache_hit;
  wire        load_stage   = holder_hit || fill_ok;
  wire [WORD_W-1:0] fill_word = pf_odd ? i_fill_data[WORD_W-1:0]
                                       : i_fill_data[LONG_W-1:WORD_W];
  wire [WORD_W-1:0] hold_word = holder[WORD_W-1:0];
  wire [WORD_W-1:0] next_in_word  = holder_hit ? hold_word : fill_word;
  wire              next_in_fault = holder_hit ? holder_fault : fill_fault;
  wire        running      = (o_proc_state != PFPS_ST_HALTED) &&
                             (o_proc_state != PFPS_ST_STOPPED);

  // Request fans out at once; a holder hit kills the bus cycle
  assign o_cache_lookup = i_pf_req && running;
  assign o_bus_start    = i_pf_req && running;
  assign o_bus_abort    = holder_hit && running;
  assign o_holder_hit   = holder_hit;
  assign o_pf_done      = load_stage && running;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pf_pending <= 1'b0;
      pf_odd     <= 1'b0;
      pf_tag     <= '0;
    end else if (i_pipe_flush || !running) begin
      pf_pending <= 1'b0;
    end else if (i_pf_req && !holder_hit) begin
      pf_pending <= 1'b1;
      pf_odd     <= req_odd;
      // Tag kept here; the address may move on before the fill lands
      pf_tag     <= i_pf_addr[31:2];
    end else if (fill_ok) begin
      pf_pending <= 1'b0;
    end
  end

  // Holder works the same with the cache enabled or not
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      holder       <= '0;
      holder_tag   <= '0;
      holder_valid <= 1'b0;
      holder_fault <= 1'b0;
    end else if (i_pipe_flush) begin
      holder_valid <= 1'b0;
    end else if (fill_ok && running) begin
      holder       <= i_fill_data;
      holder_tag   <= pf_tag;
      holder_valid <= !fill_fault;
      holder_fault <= fill_fault;
    end
  end

  // Words enter stage 0, move to 1 then 2
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || i_pipe_flush) begin
      for (int i = 0; i < PFPS_STAGES; i++) begin
        stage_word[i]  <= '0;
        stage_valid[i] <= 1'b0;
        stage_fault[i] <= 1'b0;
      end
    end else if (running) begin
      if (i_pipe_advance) begin
        stage_word[2]  <= stage_word[1];
        stage_fault[2] <= stage_fault[1];
        stage_valid[2] <= stage_valid[1] && i_pf_validate;
        stage_word[1]  <= stage_word[0];
        stage_fault[1] <= stage_fault[0];
        stage_valid[1] <= stage_valid[0];
        stage_valid[0] <= 1'b0;
      end
      if (load_stage) begin
        stage_word[0]  <= next_in_word;
        stage_fault[0] <= next_in_fault;
        stage_valid[0] <= 1'b1;
      end
    end
  end

  assign o_decode_word  = stage_word[2];
  assign o_decode_valid = stage_valid[2];
  assign o_decode_fault = stage_fault[2];
  assign o_stage1_word  = stage_word[0];
  assign o_stage2_word  = stage_word[1];

  ////////////////////////////////////////////////////////////////////////////
  // Processing state machine

  pfps_state_t state;
  pfps_state_t next_state;

  wire exc_error  = i_exc_bus_error || i_exc_addr_error;
  wire trap_req   = i_priv_attempt && !o_status_word[PFPS_SW_S_BIT];

  always_comb begin
    next_state = state;
    unique case (state)
      PFPS_ST_NORMAL: begin
        if (i_exc_start || trap_req) begin
          next_state = PFPS_ST_EXCEPTION;
        end else if (i_stop_exec) begin
          next_state = PFPS_ST_STOPPED;
        end
      end
      PFPS_ST_EXCEPTION: begin
        if (exc_error) begin
          next_state = PFPS_ST_HALTED;
        end else if (i_handler_start) begin
          next_state = PFPS_ST_NORMAL;
        end
      end
      // Only reset leaves here
      PFPS_ST_HALTED:  next_state = PFPS_ST_HALTED;
      PFPS_ST_STOPPED: begin
        if (i_stop_wake || i_exc_start) begin
          next_state = PFPS_ST_EXCEPTION;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state <= PFPS_ST_EXCEPTION;
    end else begin
      state <= next_state;
    end
  end

  assign o_proc_state = state;
  assign o_halted     = (state == PFPS_ST_HALTED);
  assign o_priv_trap  = trap_req && (state == PFPS_ST_NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // Status word, stack pointers, space codes

  logic [15:0] status_word;
  logic        saved_master;
  logic [31:0] user_stack_pointer;
  logic [31:0] irq_stack_pointer;
  logic [31:0] task_stack_pointer;

  wire enter_exc = (state != PFPS_ST_EXCEPTION) && (next_state == PFPS_ST_EXCEPTION);
  wire sup_bit   = status_word[PFPS_SW_S_BIT];
  wire mst_bit   = status_word[PFPS_SW_M_BIT];

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      status_word  <= PFPS_SW_RESET;
      saved_master <= 1'b0;
    end else if (enter_exc) begin
      saved_master                <= mst_bit;
      status_word[PFPS_SW_S_BIT]  <= 1'b1;
      if (i_exc_is_irq && !trap_req) begin
        status_word[PFPS_SW_M_BIT] <= 1'b0;
      end
    end else if (i_sw_write && sup_bit && state == PFPS_ST_NORMAL) begin
      status_word <= i_sw_wdata;
    end
  end

  // Privilege comes from the supervisor bit or the exception state, master is ignored
  wire       sup_level = sup_bit || (state == PFPS_ST_EXCEPTION);
  wire [1:0] sp_sel    = !sup_level ? PFPS_SP_USER :
                         (mst_bit ? PFPS_SP_TASK : PFPS_SP_IRQ);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      user_stack_pointer <= PFPS_SP_RESET;
      irq_stack_pointer  <= PFPS_SP_RESET;
      task_stack_pointer <= PFPS_SP_RESET;
    end else if (i_sp_write) begin
      unique case (sp_sel)
        PFPS_SP_USER: user_stack_pointer <= i_sp_wdata;
        PFPS_SP_TASK: task_stack_pointer <= i_sp_wdata;
        default:      irq_stack_pointer  <= i_sp_wdata;
      endcase
    end
  end

  assign o_stack_pointer = (sp_sel == PFPS_SP_USER) ? user_stack_pointer :
                           (sp_sel == PFPS_SP_TASK) ? task_stack_pointer : irq_stack_pointer;
  assign o_sp_select     = sp_sel;
  assign o_status_word   = status_word;
  assign o_saved_master  = saved_master;

  // Prefetch cycles count as program space
  wire [1:0] acc = i_pf_req ? PFPS_ACC_PROG : i_acc_kind;
  assign o_space_code = (acc == PFPS_ACC_CPU)  ? PFPS_FC_CPU :
                        (acc == PFPS_ACC_PROG) ?
                          (sup_level ? PFPS_FC_SUP_PROG : PFPS_FC_USER_PROG) :
                          (sup_level ? PFPS_FC_SUP_DATA : PFPS_FC_USER_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_halt_sticks: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_HALTED |=> state == PFPS_ST_HALTED)
    else $error("halted state left without reset");

  a_exc_err_halts: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_EXCEPTION && exc_error |=> o_halted)
    else $error("error in exception did not halt");

  a_exc_sup_code: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_EXCEPTION |-> o_space_code[2])
    else $error("exception cycle not supervisor");

  a_user_code: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_NORMAL && !sup_bit && (i_pf_req || i_acc_kind != PFPS_ACC_CPU) |->
      !o_space_code[2] && o_sp_select == PFPS_SP_USER)
    else $error("user level not tagged user");

  a_master_stack: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    sup_level |-> o_sp_select == (mst_bit ? PFPS_SP_TASK : PFPS_SP_IRQ))
    else $error("wrong supervisor stack");

  a_irq_clr_m: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    enter_exc && i_exc_is_irq && !trap_req |=> !status_word[PFPS_SW_M_BIT] && saved_master == $past(mst_bit))
    else $error("interrupt did not save and clear master");

  a_hit_no_bus: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    holder_hit && running && !i_pipe_flush |-> o_bus_abort ##1 (o_stage1_word == $past(hold_word)))
    else $error("holder hit not served from holder");

  a_stop_no_bus: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_STOPPED |-> !o_bus_start && !o_pf_done)
    else $error("bus activity while stopped");

  a_fault_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    fill_ok && running && !holder_hit && !i_pipe_flush |=> stage_fault[0] == $past(fill_fault))
    else $error("stage fault flag wrong");

  a_trap_enters: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_NORMAL && trap_req |=> state == PFPS_ST_EXCEPTION && sup_bit)
    else $error("privilege attempt did not trap");

  // Checked through reset itself, so no disable here
  a_reset_super: assert property (@(posedge i_mclk)
    !i_resetn |=> state == PFPS_ST_EXCEPTION && status_word == PFPS_SW_RESET && o_sp_select == PFPS_SP_IRQ)
    else $error("reset did not start in supervisor interrupt mode");

  a_stage_shift: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_pipe_advance && running && !i_pipe_flush |=>
      stage_word[2] == $past(stage_word[1]) && stage_word[1] == $past(stage_word[0]))
    else $error("pipe words did not advance");

  a_decode_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_pipe_advance && running && !i_pipe_flush && !i_pf_validate |=> !o_decode_valid)
    else $error("decode word valid without validation");

  a_stage_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !load_stage && !i_pipe_flush |=> $stable(stage_word[0]))
    else $error("first stage changed without prefetch");

  a_aligned_fill: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    fill_ok && running && !i_pipe_flush && !holder_hit && !pf_odd |=>
      holder == $past(i_fill_data) && o_stage1_word == holder[LONG_W-1:WORD_W])
    else $error("aligned fill did not load holder and upper word");

  a_req_fanout: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_pf_req && running |-> o_cache_lookup && o_bus_start)
    else $error("prefetch not sent to cache and bus");

  a_irq_stack: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    sup_level && !mst_bit |-> o_stack_pointer == irq_stack_pointer)
    else $error("interrupt mode not on irq stack");

  a_user_stack: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !sup_level |-> o_stack_pointer == user_stack_pointer)
    else $error("user level not on user stack");

  a_master_priv: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    state == PFPS_ST_NORMAL && sup_bit && mst_bit |-> !o_priv_trap)
    else $error("master mode lost privilege");

endmodule : pfps_core

`default_nettype wire

/* File: verification/pfps_bus_model.sv */
// Behavioural bus controller and instruction cache answering prefetches
`timescale 1ns/1ps
`default_nettype none

module pfps_bus_model (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // Requests from the block
  input  wire logic        i_bus_start,
  input  wire logic        i_bus_abort,
  input  wire logic [31:0] i_addr,
  // Scenario controls
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_use_cache,
  input  wire logic        i_fault,
  // Answers
  output logic             o_cache_hit,
  output logic             o_bus_done,
  output logic             o_bus_fault,
  output logic [31:0]      o_fill_data
);
  logic        pend;
  logic [3:0]  cnt;
  logic [31:0] addr;
  logic [31:0] last;
  wire logic   ans;

  assign ans         = pend && (cnt == 4'h0);
  assign o_cache_hit = ans && i_use_cache && !i_fault;
  assign o_bus_done  = ans && !i_use_cache && !i_fault;
  assign o_bus_fault = ans && i_fault;
  // Idle data keeps toggling so a late sample never sees a stale word
  assign o_fill_data = ans ? {addr[15:0] ^ 16'hc3c3, addr[15:0]} : ~last;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pend <= 1'b0;
      cnt  <= 4'h0;
      last <= 32'h0;
    end else if (i_bus_start && !i_bus_abort) begin
      pend <= 1'b1;
      cnt  <= i_delay;
      addr <= i_addr;
    end else if (ans) begin
      pend <= 1'b0;
      last <= o_fill_data;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end else begin
      last <= ~last;
    end
  end
endmodule : pfps_bus_model

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking testbench for the prefetch pipe and privilege state block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pfps_pkg::*;
  localparam int EXC = 0, HS = 1, BERR = 2, AERR = 3, STP = 4, WAKE = 5;
  localparam int PRIV = 6, SWW = 7, SPW = 8, ADV = 9, FL = 10;
  localparam logic [31:0] A0 = 32'h0000_1230;
  logic        i_mclk = 1'b0, i_resetn = 1'b0;
  logic        i_pf_req = 1'b0, i_pf_validate = 1'b0, i_exc_is_irq = 1'b0;
  logic [31:0] i_pf_addr = 32'h0, i_sp_wdata = 32'h0;
  logic [15:0] i_sw_wdata = 16'h0;
  logic [1:0]  i_acc_kind = 2'h0;
  logic [10:0] ev = 11'h0;
  logic [3:0]  dly = 4'h2;
  logic        use_c = 1'b0, flt = 1'b0;
  logic        bs, lk, hit, ab, tr;
  logic [2:0]  fc;
  logic [2:0]  fct [3] = '{PFPS_FC_USER_DATA, PFPS_FC_USER_PROG, PFPS_FC_CPU};
  int          bad_count = 0, checked = 0;
  wire logic   i_cache_hit, i_bus_done, i_bus_fault;
  wire logic [31:0] i_fill_data;
  wire logic   i_exc_start = ev[EXC], i_handler_start = ev[HS], i_exc_bus_error = ev[BERR];
  wire logic   i_exc_addr_error = ev[AERR], i_stop_exec = ev[STP], i_stop_wake = ev[WAKE];
  wire logic   i_priv_attempt = ev[PRIV], i_sw_write = ev[SWW], i_sp_write = ev[SPW];
  wire logic   i_pipe_advance = ev[ADV], i_pipe_flush = ev[FL];
  logic [15:0] o_decode_word, o_stage1_word, o_stage2_word, o_status_word;
  logic        o_decode_valid, o_decode_fault, o_holder_hit, o_pf_done, o_bus_start, o_bus_abort;
  logic        o_cache_lookup, o_halted, o_priv_trap, o_saved_master;
  logic [2:0]  o_space_code;
  logic [1:0]  o_proc_state, o_sp_select;
  logic [31:0] o_stack_pointer;

  always #12.5 i_mclk = ~i_mclk;

  pfps_core dut (.i_mclk, .i_resetn, .i_pf_req, .i_pf_addr, .i_pf_validate, .i_pipe_advance, .i_pipe_flush,
    .i_cache_hit, .i_bus_done, .i_bus_fault, .i_fill_data, .i_exc_start, .i_exc_is_irq, .i_handler_start,
    .i_exc_bus_error, .i_exc_addr_error, .i_stop_exec, .i_stop_wake, .i_priv_attempt, .i_sw_write,
    .i_sw_wdata, .i_acc_kind, .i_sp_write, .i_sp_wdata, .o_decode_word, .o_decode_valid, .o_decode_fault,
    .o_stage1_word, .o_stage2_word, .o_holder_hit, .o_pf_done, .o_bus_start, .o_bus_abort, .o_cache_lookup,
    .o_space_code, .o_proc_state, .o_halted, .o_priv_trap, .o_status_word, .o_saved_master, .o_sp_select,
    .o_stack_pointer);

  pfps_bus_model bus (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_bus_start(o_bus_start),
    .i_bus_abort(o_bus_abort), .i_addr(i_pf_addr), .i_delay(dly), .i_use_cache(use_c), .i_fault(flt),
    .o_cache_hit(i_cache_hit), .o_bus_done(i_bus_done), .o_bus_fault(i_bus_fault), .o_fill_data(i_fill_data));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] hi(input logic [31:0] a);
    return a[15:0] ^ 16'hc3c3;
  endfunction : hi

  task automatic stop_test();
    $display("Checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rst();
    @(posedge i_mclk) i_resetn <= 1'b0;
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(negedge i_mclk);
  endtask : rst

  // One-cycle event pulse; data rides along for the write events
  task automatic pulse(input int b, input logic [31:0] d);
    @(posedge i_mclk);
    ev <= 11'h1 << b;
    i_sw_wdata <= d[15:0];
    i_sp_wdata <= d;
    @(negedge i_mclk) tr = o_priv_trap;
    @(posedge i_mclk) ev <= 11'h0;
    @(negedge i_mclk);
  endtask : pulse

  task automatic acc(input logic [1:0] k);
    @(posedge i_mclk) i_acc_kind <= k;
    @(negedge i_mclk);
  endtask : acc

  // Prefetch; w waits for the stage load under a bounded count
  task automatic pf(input logic [31:0] a, input bit w);
    int n;
    @(posedge i_mclk);
    i_pf_req <= 1'b1;
    i_pf_addr <= a;
    @(negedge i_mclk);
    {bs, lk, hit, ab, fc} = {o_bus_start, o_cache_lookup, o_holder_hit, o_bus_abort, o_space_code};
    n = 0;
    while (w && o_pf_done !== 1'b1 && n < 20) begin
      @(posedge i_mclk) i_pf_req <= 1'b0;
      @(negedge i_mclk) n++;
    end
    @(posedge i_mclk) i_pf_req <= 1'b0;
    @(negedge i_mclk);
    if (n == 20) begin
      bad_count++;
      stop_test();
    end
  endtask : pf

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    stop_test();
  end

  initial begin
    rst();
    chk("state", 32'(PFPS_ST_EXCEPTION), 32'(o_proc_state));
    chk("sw", 32'(PFPS_SW_RESET), 32'(o_status_word));
    chk("spsel", 32'(PFPS_SP_IRQ), 32'(o_sp_select));
    chk("fc", 32'(PFPS_FC_SUP_DATA), 32'(o_space_code));
    pf(A0, 1'b1);
    chk("start", 32'h3, 32'({bs, lk}));
    chk("fcpf", 32'(PFPS_FC_SUP_PROG), 32'(fc));
    chk("s0", 32'(hi(A0)), 32'(o_stage1_word));
    pulse(HS, 0);
    chk("state", 32'(PFPS_ST_NORMAL), 32'(o_proc_state));
    @(posedge i_mclk) i_pf_validate <= 1'b1;
    pulse(ADV, 0);
    chk("dvalid", 32'h0, 32'(o_decode_valid));
    chk("s1", 32'(hi(A0)), 32'(o_stage2_word));
    pf(A0 + 2, 1'b1);
    chk("hit", 32'h3, 32'({hit, ab}));
    chk("s0lo", 32'h1230, 32'(o_stage1_word));
    pulse(ADV, 0);
    chk("dword", 32'(hi(A0)), 32'(o_decode_word));
    chk("dvalid", 32'h1, 32'(o_decode_valid));
    use_c = 1'b1;
    dly = 4'h0;
    pf(A0 + 4, 1'b1);
    chk("s0c", 32'(hi(A0 + 4)), 32'(o_stage1_word));
    pf(A0 + 6, 1'b1);
    chk("hitc", 32'h1, 32'(hit));
    use_c = 1'b0;
    flt = 1'b1;
    @(posedge i_mclk) i_pf_validate <= 1'b0;
    pf(A0 + 8, 1'b1);
    pulse(ADV, 0);
    pulse(ADV, 0);
    chk("dfault", 32'h1, 32'(o_decode_fault));
    chk("dvalid", 32'h0, 32'(o_decode_valid));
    chk("dword", 32'(hi(A0 + 8)), 32'(o_decode_word));
    flt = 1'b0;
    pulse(FL, 0);
    pf(A0 + 10, 1'b1);
    chk("hitfl", 32'h0, 32'(hit));
    pulse(SWW, 0);
    chk("spsel", 32'(PFPS_SP_USER), 32'(o_sp_select));
    for (int k = 0; k < 3; k++) begin
      acc(2'(k));
      chk("fc", 32'(fct[k]), 32'(o_space_code));
    end
    pulse(SPW, 32'h1000);
    chk("sp", 32'h1000, o_stack_pointer);
    pulse(PRIV, 0);
    chk("trap", 32'h1, 32'(tr));
    chk("sbit", 32'h1, 32'(o_status_word[PFPS_SW_S_BIT]));
    chk("spsel", 32'(PFPS_SP_IRQ), 32'(o_sp_select));
    pulse(HS, 0);
    pulse(SWW, 32'h3000);
    chk("spsel", 32'(PFPS_SP_TASK), 32'(o_sp_select));
    pulse(SPW, 32'h2000);
    pulse(PRIV, 0);
    chk("trapm", 32'h0, 32'(tr));
    chk("sp", 32'h2000, o_stack_pointer);
    @(posedge i_mclk) i_exc_is_irq <= 1'b1;
    pulse(EXC, 0);
    chk("savm", 32'h1, 32'(o_saved_master));
    chk("mbit", 32'h0, 32'(o_status_word[PFPS_SW_M_BIT]));
    chk("sp", 32'h0, o_stack_pointer);
    pulse(BERR, 0);
    chk("halt", 32'h1, 32'(o_halted));
    pf(A0, 1'b0);
    chk("nobus", 32'h0, 32'(bs));
    pulse(HS, 0);
    chk("state", 32'(PFPS_ST_HALTED), 32'(o_proc_state));
    rst();
    chk("halt", 32'h0, 32'(o_halted));
    chk("state", 32'(PFPS_ST_EXCEPTION), 32'(o_proc_state));
    chk("sw", 32'(PFPS_SW_RESET), 32'(o_status_word));
    chk("spsel", 32'(PFPS_SP_IRQ), 32'(o_sp_select));
    pulse(AERR, 0);
    chk("state", 32'(PFPS_ST_HALTED), 32'(o_proc_state));
    rst();
    pulse(HS, 0);
    pulse(STP, 0);
    chk("state", 32'(PFPS_ST_STOPPED), 32'(o_proc_state));
    pf(A0, 1'b0);
    chk("nobus", 32'h0, 32'(bs));
    pulse(WAKE, 0);
    chk("state", 32'(PFPS_ST_EXCEPTION), 32'(o_proc_state));
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
